// File: common/seq_map.svh
// Purpose : Register offsets, field positions and reset values of the sequencer
// Assumes : Byte addresses on a 32-bit classic Wishbone slave
// Notes   : Definitions only
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define SEQ_CTRL_OFS      12'h000
`define SEQ_INITSEL_OFS   12'h004
`define SEQ_CLKSEL_OFS    12'h008
`define SEQ_CMP0_OFS      12'h00C
`define SEQ_CMP1_OFS      12'h010
`define SEQ_STATUS_OFS    12'h014
`define SEQ_TERM_BASE     12'h100
`define SEQ_TERM_LAST     12'h1FF

// ----------------------------------------------------------------------------
// Term field selectors (address bits 3:2 inside one term)
// ----------------------------------------------------------------------------
`define SEQ_TERM_TRUE     2'h0
`define SEQ_TERM_CPL      2'h1
`define SEQ_TERM_JSEL     2'h2
`define SEQ_TERM_KSEL     2'h3

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SEQ_CTRL_MODE_LSB 0
`define SEQ_CTRL_DIAG_OUT 2
`define SEQ_CTRL_DIAG_ST  3
`define SEQ_ST_COMP0      16
`define SEQ_ST_COMP1      17
`define SEQ_ST_INIT       18
`define SEQ_ST_PD         19

// ----------------------------------------------------------------------------
// Reset values (unprogrammed part)
// ----------------------------------------------------------------------------
`define SEQ_CTRL_RST      32'h0000_0000
`define SEQ_INITSEL_RST   32'hFFFF_FFFF
`define SEQ_CLKSEL_RST    32'h0000_0000
`define SEQ_CMP_RST       32'h0000_0000
`define SEQ_MASK_RST      32'hFFFF_FFFF
`define SEQ_JK_RST        32'h0000_0000
`define SEQ_REG_PWRUP     32'hFFFF_FFFF

`endif

// File: common/seq_pkg.sv
// Purpose : Types shared by the sequencer files
// Assumes : Classic Wishbone, 32-bit data
// Notes   : Offsets and values live in seq_map.svh
package seq_pkg;

   // -------------------------------------------------------------------------
   // Bus carriers
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [31:0] adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_t;

   // -------------------------------------------------------------------------
   // Multifunction pin use, Gray coded
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      MF_INIT  = 2'b00,
      MF_OE    = 2'b01,
      MF_PD    = 2'b11,
      MF_LOGIC = 2'b10
   } mf_mode_t;

endpackage : seq_pkg

// File: rtl/pin_filter.sv
// Purpose : Three-stage synchroniser with agreement filter for pin inputs
// Assumes : Inputs asynchronous to clk_i
// Notes   : Output moves only when stages two and three agree
module pin_filter #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   import seq_pkg::*;

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] lvl_ff;

   // -------------------------------------------------------------------------
   // Stages
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else if (ce_i) begin
         s1_ff <= pin_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Stage one is seen by stage two only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_ff <= '0;
      end else if (ce_i) begin
         for (int b = 0; b < W; b++) begin
            if (s2_ff[b] == s3_ff[b]) begin
               lvl_ff[b] <= s3_ff[b];
            end
         end
      end
   end

   assign level_o = lvl_ff;

endmodule : pin_filter

// File: rtl/sequencer_complement_init.sv
// Purpose : Fuse-programmable J/K sequencer with complement arrays and init
// Assumes : One clock; clock pins and all pins sampled as slow levels
// Notes   : Fuse map held in flip-flops, reached over classic Wishbone
`include "seq_map.svh"

// Overview of operation
// - Init loads each register's own preset/reset choice
// - Diagnostic mode tri-states pins, pins load registers
// - Unprogrammed multifunction pin acts as init input
// - Power-up presets every register to one
// - Unprogrammed transition terms evaluate to zero
// - Unprogrammed J and K inputs held low
// - Unprogrammed complement arrays have no terms
// - Unprogrammed, clock one drives every register
// - Complement array ORs terms, inverts, feeds back
// - Complement low if any connected term high
// - Two independent complement arrays are provided
// - Init high overrides and inhibits clocking
// - Power-down places all outputs in high impedance
module sequencer_complement_init
   import seq_pkg::*;
#(
   parameter int NUM_IN    = 12,
   parameter int NUM_STATE = 8,
   parameter int NUM_OUT   = 8,
   parameter int NUM_TERMS = 16
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   input  wire wb_req_t              wb_req_i,
   output wb_rsp_t                   wb_rsp_o,
   input  wire logic [NUM_IN-1:0]    in_pins_i,
   input  wire logic                 clk1_pin_i,
   input  wire logic                 clk2_pin_i,
   input  wire logic                 multifunction_control_pin_i,
   input  wire logic [NUM_OUT-1:0]   output_pins_i,
   output logic      [NUM_OUT-1:0]   output_pins_o,
   output logic      [NUM_OUT-1:0]   output_pins_oe_o
);

   // -------------------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------------------
   localparam int NREG  = NUM_STATE + NUM_OUT;
   localparam int LIT_W = NUM_IN + 1 + NREG + 2;
   localparam int PIN_W = NUM_IN + NUM_OUT + 3;

   // Status keeps its flags above bit 15, so at most 16 registers fit
   if (LIT_W > 32 || NREG > 16 || NUM_TERMS > 16 || NUM_TERMS < 1 ||
       NUM_STATE != NUM_OUT) begin : g_size_check
      $error("sequencer_complement_init: unsupported sizes");
   end

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   logic [31:0]           ctrl_ff;
   logic [31:0]           initsel_ff;
   logic [31:0]           clksel_ff;
   logic [31:0]           cmp_ff     [2];
   logic [31:0]           tru_ff     [NUM_TERMS];
   logic [31:0]           cpl_ff     [NUM_TERMS];
   logic [31:0]           jm_ff      [NUM_TERMS];
   logic [31:0]           km_ff      [NUM_TERMS];
   logic [NREG-1:0]       q_ff;
   logic [NREG-1:0]       nxt_q;
   logic [1:0]            lock_ff;
   logic [1:0]            ckp_ff;
   logic                  ack_ff;
   logic [31:0]           dat_ff;
   logic [31:0]           rd_data;
   logic [PIN_W-1:0]      pin_lvl;
   logic [NUM_IN-1:0]     in_lvl;
   logic [NUM_OUT-1:0]    fpin_lvl;
   logic [1:0]            ck_lvl;
   logic                  mf_lvl;
   mf_mode_t              mode;
   logic                  init_act;
   logic                  power_down_input;
   logic                  diag_out;
   logic                  diag_st;
   logic [1:0]            ck_rise;
   logic [1:0]            ck_fall;
   logic [NUM_TERMS-1:0]  pre_terms;
   logic [NUM_TERMS-1:0]  terms;
   logic [1:0]            comp;
   logic [LIT_W-1:0]      lit_pre;
   logic [LIT_W-1:0]      lit;
   logic [NREG-1:0]       j_vec;
   logic [NREG-1:0]       k_vec;
   logic                  bus_req;
   logic                  wr_en;

   // -------------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = dat[8*b +: 8];
         end
      end
      return res;
   endfunction : merge

   // Term window decode, used by read and write paths
   function automatic logic term_hit(input logic [31:0] adr);
      logic [3:0] idx;
      idx = adr[7:4];
      return (adr[11:0] >= `SEQ_TERM_BASE) && (adr[11:0] <= `SEQ_TERM_LAST) &&
             (adr[31:12] == 20'h0_0000) && (int'(idx) < NUM_TERMS);
   endfunction : term_hit

   // Intact true and complement links together force a term to zero
   function automatic logic eval_term(input logic [LIT_W-1:0] l,
                                      input logic [31:0]      t,
                                      input logic [31:0]      c);
      return &((~t[LIT_W-1:0] | l) & (~c[LIT_W-1:0] | ~l));
   endfunction : eval_term

   // -------------------------------------------------------------------------
   // Pin sampling
   // -------------------------------------------------------------------------
   pin_filter #(
      .W (PIN_W)
   ) u_pins (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .pin_i   ({multifunction_control_pin_i, clk2_pin_i, clk1_pin_i,
                 output_pins_i, in_pins_i}),
      .level_o (pin_lvl)
   );

   assign in_lvl   = pin_lvl[NUM_IN-1:0];
   assign fpin_lvl = pin_lvl[NUM_IN +: NUM_OUT];
   assign ck_lvl   = pin_lvl[NUM_IN+NUM_OUT +: 2];
   assign mf_lvl   = pin_lvl[PIN_W-1];

   // -------------------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------------------
   assign mode             = mf_mode_t'(ctrl_ff[`SEQ_CTRL_MODE_LSB +: 2]);
   assign init_act         = (mode == MF_INIT) && mf_lvl;
   assign power_down_input = (mode == MF_PD) && mf_lvl;
   assign diag_out         = ctrl_ff[`SEQ_CTRL_DIAG_OUT];
   assign diag_st          = ctrl_ff[`SEQ_CTRL_DIAG_ST];

   // -------------------------------------------------------------------------
   // Clock edges and init lockout
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ckp_ff <= 2'h0;
      end else if (ce_i) begin
         ckp_ff <= ck_lvl;
      end
   end

   assign ck_rise = ck_lvl & ~ckp_ff & ~lock_ff;
   assign ck_fall = ~ck_lvl & ckp_ff;

   // Clocking comes back only after a high-to-low transition of that clock pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_ff <= 2'h0;
      end else if (ce_i) begin
         for (int c = 0; c < 2; c++) begin
            if (init_act) begin
               lock_ff[c] <= 1'b1;
            end else if (ck_fall[c]) begin
               lock_ff[c] <= 1'b0;
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // AND array and complement arrays
   // -------------------------------------------------------------------------
   // Complement literals are taken as don't care in the first pass;
   // this breaks the feedback loop at the cost of nesting complements
   always_comb begin
      lit_pre = {2'b00, q_ff, (mode == MF_LOGIC) & mf_lvl, in_lvl};
      for (int t = 0; t < NUM_TERMS; t++) begin
         pre_terms[t] = eval_term(lit_pre,
                                  32'(tru_ff[t][LIT_W-3:0]),
                                  32'(cpl_ff[t][LIT_W-3:0]));
      end
   end

   // Empty array stays inactive rather than reading as high
   always_comb begin
      for (int a = 0; a < 2; a++) begin
         comp[a] = ~|(pre_terms & cmp_ff[a][NUM_TERMS-1:0]) &
                   (|cmp_ff[a][NUM_TERMS-1:0]);
      end
   end

   always_comb begin
      lit = {comp, q_ff, (mode == MF_LOGIC) & mf_lvl, in_lvl};
      for (int t = 0; t < NUM_TERMS; t++) begin
         terms[t] = eval_term(lit, tru_ff[t], cpl_ff[t]);
      end
   end

   // -------------------------------------------------------------------------
   // OR array onto J and K
   // -------------------------------------------------------------------------
   for (genvar r = 0; r < NREG; r++) begin : g_jk
      always_comb begin
         j_vec[r] = 1'b0;
         k_vec[r] = 1'b0;
         for (int t = 0; t < NUM_TERMS; t++) begin
            j_vec[r] = j_vec[r] | (terms[t] & jm_ff[t][r]);
            k_vec[r] = k_vec[r] | (terms[t] & km_ff[t][r]);
         end
      end
   end

   // -------------------------------------------------------------------------
   // State and output registers
   // -------------------------------------------------------------------------
   always_comb begin
      nxt_q = q_ff;
      for (int r = 0; r < NREG; r++) begin
         if (ck_rise[clksel_ff[r]]) begin
            if (r >= NUM_STATE && diag_out) begin
               nxt_q[r] = fpin_lvl[r-NUM_STATE];
            end else if (r < NUM_STATE && diag_st) begin
               nxt_q[r] = fpin_lvl[r];
            end else begin
               nxt_q[r] = (j_vec[r] & ~q_ff[r]) | (~k_vec[r] & q_ff[r]);
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_ff <= NREG'(`SEQ_REG_PWRUP);
      end else if (ce_i) begin
         if (init_act) begin
            q_ff <= initsel_ff[NREG-1:0];
         end else if (!power_down_input) begin
            q_ff <= nxt_q;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Output pins
   // -------------------------------------------------------------------------
   assign output_pins_o = q_ff[NUM_STATE +: NUM_OUT];

   always_comb begin
      if (power_down_input || diag_out || diag_st) begin
         output_pins_oe_o = '0;
      end else if (mode == MF_OE) begin
         output_pins_oe_o = {NUM_OUT{~mf_lvl}};
      end else begin
         output_pins_oe_o = '1;
      end
   end

   // -------------------------------------------------------------------------
   // Wishbone slave
   // -------------------------------------------------------------------------
   assign bus_req = wb_req_i.cyc && wb_req_i.stb && !ack_ff;
   assign wr_en   = bus_req && wb_req_i.we;

   always_comb begin
      rd_data = 32'h0000_0000;
      if (term_hit(wb_req_i.adr)) begin
         unique case (wb_req_i.adr[3:2])
            `SEQ_TERM_TRUE: rd_data = tru_ff[wb_req_i.adr[7:4]];
            `SEQ_TERM_CPL:  rd_data = cpl_ff[wb_req_i.adr[7:4]];
            `SEQ_TERM_JSEL: rd_data = jm_ff[wb_req_i.adr[7:4]];
            `SEQ_TERM_KSEL: rd_data = km_ff[wb_req_i.adr[7:4]];
         endcase
      end else if (wb_req_i.adr[31:12] == 20'h0_0000) begin
         case (wb_req_i.adr[11:0])
            `SEQ_CTRL_OFS:    rd_data = ctrl_ff;
            `SEQ_INITSEL_OFS: rd_data = initsel_ff;
            `SEQ_CLKSEL_OFS:  rd_data = clksel_ff;
            `SEQ_CMP0_OFS:    rd_data = cmp_ff[0];
            `SEQ_CMP1_OFS:    rd_data = cmp_ff[1];
            `SEQ_STATUS_OFS: begin
               rd_data[NREG-1:0]        = q_ff;
               rd_data[`SEQ_ST_COMP0]   = comp[0];
               rd_data[`SEQ_ST_COMP1]   = comp[1];
               rd_data[`SEQ_ST_INIT]    = init_act;
               rd_data[`SEQ_ST_PD]      = power_down_input;
            end
            default:          rd_data = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_ff <= bus_req;
         if (bus_req && !wb_req_i.we) begin
            dat_ff <= rd_data;
         end
      end
   end

   assign wb_rsp_o.ack = ack_ff;
   assign wb_rsp_o.dat = dat_ff;

   // -------------------------------------------------------------------------
   // Control registers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff    <= `SEQ_CTRL_RST;
         initsel_ff <= `SEQ_INITSEL_RST;
         clksel_ff  <= `SEQ_CLKSEL_RST;
         cmp_ff[0]  <= `SEQ_CMP_RST;
         cmp_ff[1]  <= `SEQ_CMP_RST;
      end else if (ce_i && wr_en && wb_req_i.adr[31:12] == 20'h0_0000) begin
         case (wb_req_i.adr[11:0])
            `SEQ_CTRL_OFS: begin
               ctrl_ff <= merge(ctrl_ff, wb_req_i.dat, wb_req_i.sel) & 32'h0000_000F;
            end
            `SEQ_INITSEL_OFS: initsel_ff <= merge(initsel_ff, wb_req_i.dat, wb_req_i.sel);
            `SEQ_CLKSEL_OFS:  clksel_ff  <= merge(clksel_ff, wb_req_i.dat, wb_req_i.sel);
            `SEQ_CMP0_OFS:    cmp_ff[0]  <= merge(cmp_ff[0], wb_req_i.dat, wb_req_i.sel);
            `SEQ_CMP1_OFS:    cmp_ff[1]  <= merge(cmp_ff[1], wb_req_i.dat, wb_req_i.sel);
            default: ;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Term link storage
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int t = 0; t < NUM_TERMS; t++) begin
            tru_ff[t] <= `SEQ_MASK_RST;
            cpl_ff[t] <= `SEQ_MASK_RST;
            jm_ff[t]  <= `SEQ_JK_RST;
            km_ff[t]  <= `SEQ_JK_RST;
         end
      end else if (ce_i && wr_en && term_hit(wb_req_i.adr)) begin
         unique case (wb_req_i.adr[3:2])
            `SEQ_TERM_TRUE: tru_ff[wb_req_i.adr[7:4]] <=
               merge(tru_ff[wb_req_i.adr[7:4]], wb_req_i.dat, wb_req_i.sel);
            `SEQ_TERM_CPL:  cpl_ff[wb_req_i.adr[7:4]] <=
               merge(cpl_ff[wb_req_i.adr[7:4]], wb_req_i.dat, wb_req_i.sel);
            `SEQ_TERM_JSEL: jm_ff[wb_req_i.adr[7:4]] <=
               merge(jm_ff[wb_req_i.adr[7:4]], wb_req_i.dat, wb_req_i.sel);
            `SEQ_TERM_KSEL: km_ff[wb_req_i.adr[7:4]] <=
               merge(km_ff[wb_req_i.adr[7:4]], wb_req_i.dat, wb_req_i.sel);
         endcase
      end
   end

   // A term wired to the complement output can steer back to a known
   // state; that is a programming choice, nothing here enforces it

endmodule : sequencer_complement_init

// File: test/seq_checker_properties.sv
// Purpose : Port-level properties of the sequencer
// Assumes : ce_i held high; mode and diag bits shadowed from bus writes
// Notes   : Bound to the top module below
module seq_checker
   import seq_pkg::*;
#(
   parameter int NUM_IN  = 12,
   parameter int NUM_OUT = 8
) (
   input wire logic               clk_i,
   input wire logic               rst_i,
   input wire logic               ce_i,
   input wire wb_req_t            wb_req_i,
   input wire wb_rsp_t            wb_rsp_o,
   input wire logic [NUM_IN-1:0]  in_pins_i,
   input wire logic               clk1_pin_i,
   input wire logic               clk2_pin_i,
   input wire logic               multifunction_control_pin_i,
   input wire logic [NUM_OUT-1:0] output_pins_i,
   input wire logic [NUM_OUT-1:0] output_pins_o,
   input wire logic [NUM_OUT-1:0] output_pins_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] mode_ff;
   logic       diag_ff;
   logic       take;
   assign take = ce_i && wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
   // ------------------------------------------------------------------
   // Control shadow
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_ff <= 2'h0;
         diag_ff <= 1'b0;
      end else if (take && wb_req_i.we && wb_req_i.adr == 32'h0000_0000) begin
         mode_ff <= wb_req_i.dat[1:0];
         diag_ff <= |wb_req_i.dat[3:2];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   sequence quiet_s;
      (!clk1_pin_i && !clk2_pin_i && !multifunction_control_pin_i)[*8];
   endsequence
   sequence init_s;
      (mode_ff == 2'h0 && multifunction_control_pin_i)[*6];
   endsequence
   ack_timing_a: assert property (take |=> wb_rsp_o.ack)
      else $error("ack missing after request");
   ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
      else $error("ack longer than one cycle");
   ack_idle_a: assert property (!wb_req_i.cyc |=> !wb_rsp_o.ack)
      else $error("ack without request");
   unmapped_zero_a: assert property (take && !wb_req_i.we && wb_req_i.adr >= 32'h0000_0018
      && wb_req_i.adr < 32'h0000_0100 |=> wb_rsp_o.dat == 32'h0000_0000)
      else $error("unmapped read not zero");
   reset_ones_a: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i && ce_i |=> output_pins_o == '1) else $error("reset value not all ones");
   hold_quiet_a: assert property (quiet_s |=> $stable(output_pins_o))
      else $error("register moved without clock");
   init_hold_a: assert property (init_s |=> $stable(output_pins_o))
      else $error("register moved during init");
   pd_float_a: assert property ((mode_ff == 2'h3 && multifunction_control_pin_i)[*6]
      |-> output_pins_oe_o == '0) else $error("output driven in power down");
   diag_float_a: assert property (diag_ff && $past(diag_ff) |-> output_pins_oe_o == '0)
      else $error("output driven in diagnostic mode");
   init_drive_a: assert property (mode_ff == 2'h0 && !diag_ff && !$past(diag_ff)
      |-> output_pins_oe_o == '1) else $error("output not driven in init mode");
endmodule : seq_checker

bind sequencer_complement_init seq_checker #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) u_seq_checker (
   .clk_i, .rst_i, .ce_i, .wb_req_i, .wb_rsp_o, .in_pins_i, .clk1_pin_i, .clk2_pin_i,
   .multifunction_control_pin_i, .output_pins_i, .output_pins_o, .output_pins_oe_o);

// File: test/sequencer_complement_init_bench.sv
// Purpose : Directed bench for the sequencer
// Assumes : Design answers every Wishbone request; pin changes seen within 8 cycles
// Notes   : ce_i held high throughout
module sequencer_complement_init_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import seq_pkg::*;
   logic        clk_i, rst_i, ce_i, clk1, clk2, mf;
   wb_req_t     req;
   wb_rsp_t     rsp;
   logic [11:0] in_pins;
   logic [7:0]  opin, pout, poe;
   logic [31:0] q;
   int          bad_count, cmp_count, cyc_n;
   sequencer_complement_init u_sequencer_complement_init (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(ce_i), .wb_req_i(req), .wb_rsp_o(rsp), .in_pins_i(in_pins), .clk1_pin_i(clk1),
      .clk2_pin_i(clk2), .multifunction_control_pin_i(mf), .output_pins_i(opin),
      .output_pins_o(pout), .output_pins_oe_o(poe));
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {20'h0_0000, a}, sel: 4'hF, dat: d};
      @(posedge clk_i);
      while (rsp.ack !== 1'b1) begin
         @(posedge clk_i);
      end
      q = rsp.dat;
      req <= '0;
      @(posedge clk_i);
   endtask : wb
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(q & m, e);
   endtask : rd
   task automatic outs(input logic [7:0] e);
      chk({24'h00_0000, pout}, {24'h00_0000, e});
   endtask : outs
   task automatic pulse(input logic two);
      if (two) clk2 <= 1'b1; else clk1 <= 1'b1;
      repeat (8) @(posedge clk_i);
      clk1 <= 1'b0;
      clk2 <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask : pulse
   // ------------------------------------------------------------------
   // Clock, timeout, sequence
   // ------------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n > 20000) begin
         bad_count++;
         report_and_stop();
      end
   end
   initial begin
      rst_i = 1'b1;
      ce_i = 1'b1;
      req = '0;
      clk1 = 1'b0;
      clk2 = 1'b0;
      mf = 1'b0;
      in_pins = 12'h000;
      opin = 8'h00;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      outs(8'hFF);
      chk({24'h00_0000, poe}, 32'h0000_00FF);
      rd(12'h000, 32'hFFFF_FFFF, 32'h0000_0000);
      rd(12'h004, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
      rd(12'h008, 32'hFFFF_FFFF, 32'h0000_0000);
      rd(12'h00C, 32'hFFFF_FFFF, 32'h0000_0000);
      rd(12'h014, 32'h0003_0000, 32'h0000_0000);
      rd(12'h018, 32'hFFFF_FFFF, 32'h0000_0000);
      pulse(1'b0);
      pulse(1'b1);
      outs(8'hFF);
      $display("test unprogrammed done");
      wb(1'b1, 12'h004, 32'h0000_5A3C);
      wb(1'b1, 12'h100, 32'h0000_0000);
      wb(1'b1, 12'h104, 32'h0000_0000);
      wb(1'b1, 12'h10C, 32'h0000_FF00);
      mf <= 1'b1;
      repeat (8) @(posedge clk_i);
      outs(8'h5A);
      rd(12'h014, 32'h0004_00FF, 32'h0004_003C);
      pulse(1'b0);
      outs(8'h5A);
      mf <= 1'b0;
      repeat (8) @(posedge clk_i);
      pulse(1'b0);
      outs(8'h5A);
      pulse(1'b0);
      outs(8'h00);
      wb(1'b1, 12'h108, 32'h0000_FF00);
      pulse(1'b0);
      outs(8'hFF);
      pulse(1'b0);
      outs(8'h00);
      wb(1'b1, 12'h10C, 32'h0000_0000);
      pulse(1'b0);
      outs(8'hFF);
      wb(1'b1, 12'h108, 32'h0000_0000);
      pulse(1'b0);
      outs(8'hFF);
      $display("test init and jk done");
      wb(1'b1, 12'h00C, 32'h0000_0001);
      wb(1'b1, 12'h010, 32'h0000_0002);
      rd(12'h014, 32'h0003_0000, 32'h0002_0000);
      wb(1'b1, 12'h100, 32'h0000_0001);
      repeat (6) @(posedge clk_i);
      rd(12'h014, 32'h0003_0000, 32'h0003_0000);
      in_pins <= 12'h001;
      repeat (6) @(posedge clk_i);
      rd(12'h014, 32'h0003_0000, 32'h0002_0000);
      in_pins <= 12'h000;
      wb(1'b1, 12'h124, 32'h0000_0000);
      wb(1'b1, 12'h120, 32'h2000_0000);
      wb(1'b1, 12'h12C, 32'h0000_FF00);
      pulse(1'b0);
      outs(8'h00);
      $display("test complement done");
      wb(1'b1, 12'h000, 32'h0000_0006);
      chk({24'h00_0000, poe}, 32'h0000_0000);
      opin <= 8'hA5;
      repeat (6) @(posedge clk_i);
      pulse(1'b0);
      outs(8'hA5);
      wb(1'b1, 12'h000, 32'h0000_0003);
      mf <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk({24'h00_0000, poe}, 32'h0000_0000);
      rd(12'h014, 32'h0008_0000, 32'h0008_0000);
      mf <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk({24'h00_0000, poe}, 32'h0000_00FF);
      wb(1'b1, 12'h000, 32'h0000_000A);
      chk({24'h00_0000, poe}, 32'h0000_0000);
      pulse(1'b0);
      rd(12'h014, 32'h0000_00FF, 32'h0000_00A5);
      wb(1'b1, 12'h000, 32'h0000_0001);
      mf <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk({24'h00_0000, poe}, 32'h0000_0000);
      mf <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk({24'h00_0000, poe}, 32'h0000_00FF);
      $display("test diagnostic and power down done");
      report_and_stop();
   end
endmodule : sequencer_complement_init_bench
